// *** common/bagc_map.svh ***
// register offsets, field positions, reset values and timing counts of the agc/test bank
`ifndef BAGC_MAP_SVH
`define BAGC_MAP_SVH
`define BAGC_OFS_TDATA 8'h2e
`define BAGC_OFS_LGAIN 8'h30
`define BAGC_OFS_MGAIN 8'h32
`define BAGC_OFS_ATEST 8'h34
`define BAGC_OFS_RFTHR 8'h36
`define BAGC_OFS_SATAT 8'h38
`define BAGC_OFS_LWNEG 8'h3a
`define BAGC_OFS_CSSCL 8'h3c
`define BAGC_OFS_TXPWR 8'h3e
`define BAGC_OFS_TEST1 8'h40
`define BAGC_OFS_TEST2 8'h42
`define BAGC_OFS_TBSEL 8'h44
`define BAGC_NREG 12
`define BAGC_RST_DEF 8'h00
`define BAGC_RST_LGAIN 8'h2d
`define BAGC_GAIN_SHIFT 6
`define BAGC_FINAL_SAMPLES 6'h20
// agc test control bits
`define BAGC_B_CONT 7
`define BAGC_B_RFPOL 6
`define BAGC_B_XDIS 5
`define BAGC_B_OVR 2
`define BAGC_B_ABORT 1
`define BAGC_B_SATEN 0
// test mode bits
`define BAGC_B_HIRATE 6
`define BAGC_B_LENCNT 5
`define BAGC_B_NOSPRD 3
`define BAGC_B_NOSCR 2
`define BAGC_B_PN44 1
`define BAGC_B_PN22 0
`define BAGC_B_TTFORCE 6
`define BAGC_B_BYPASS 4
`define BAGC_B_TADIS 3
`define BAGC_B_LOOP 2
`endif

// *** common/bagc_pkg.sv ***
// types shared by the agc/test configuration bank
package bagc_pkg;
  typedef logic [7:0] bagc_byte_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bagc_req_s;
  typedef enum logic [1:0] {BAGC_IDLE, BAGC_FINAL, BAGC_DONE} bagc_fin_e;
endpackage

// *** logic/bagc_regs.sv ***
// agc test configuration bank with gain override, saturation steps and test modes
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "bagc_map.svh"
module bagc_regs
  import bagc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire bagc_req_s         req_i,
  output logic       [7:0]       rdata_o,
  input  wire logic              table_read_i,
  input  wire logic  [4:0]       table_addr_i,
  input  wire logic  [7:0]       saturation_count_register_i,
  input  wire logic              receiver_config_bit2_i,
  input  wire logic              agc_rf_i,
  input  wire logic  [6:0]       agc_if_i,
  input  wire logic  [6:0]       agc_voltage_i,
  input  wire logic  signed [7:0] agc_err_i,
  input  wire logic              agc_freeze_i,
  input  wire logic              agc_lock_i,
  input  wire logic              sample_stb_i,
  input  wire logic              ant2_search_i,
  input  wire logic              ant2_power_low_i,
  input  wire logic              ant2_lock_i,
  input  wire logic  [4:0]       sat_count_i,
  input  wire logic  [3:0]       sat_level_i,
  input  wire logic              transmit_enable_input_i,
  input  wire logic              service_bit2_i,
  input  wire logic              serial_data_input_i,
  input  wire logic  [7:0]       test_bus_inputs_i,
  input  wire logic  [5:0]       adc_i_i,
  input  wire logic  [5:0]       adc_q_i,
  output logic                   rf_gain_line_o,
  output logic       [6:0]       if_gain_line_o,
  output logic signed [7:0]      loop_update_o,
  output logic                   agc_update_en_o,
  output logic                   final_update_o,
  output logic                   ant2_dwell_end_o,
  output logic       [4:0]       sat_atten_step_o,
  output logic signed [5:0]      lock_window_neg_o,
  output logic       [5:0]       carrier_sense_second_scale_o,
  output logic       [6:0]       tx_power_o,
  output logic                   length_in_bits_o,
  output logic                   scrambler_off_o,
  output logic                   spread_off_o,
  output logic                   force_high_rate_o,
  output logic                   pn44_en_o,
  output logic                   pn22_en_o,
  output logic                   pn44_init_o,
  output logic                   pn22_init_o,
  output logic                   locked_tracking_o,
  output logic                   loopback_o,
  output logic                   acq_lock_o,
  output logic       [5:0]       sample_i_o,
  output logic       [5:0]       sample_q_o,
  output logic       [7:0]       test_bus_select_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  bagc_byte_t       regs_ff [`BAGC_NREG];
  logic [6:0]       table_ff [32];
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;
  logic [7:0]       ofs;
  logic             hit;
  logic [3:0]       idx;

  // registers sit on even byte offsets from table data upward
  assign ofs = req_i.addr - `BAGC_OFS_TDATA;
  assign hit = (req_i.addr >= `BAGC_OFS_TDATA) && (req_i.addr <= `BAGC_OFS_TBSEL)
               && !req_i.addr[0];
  assign idx = ofs[4:1];

  // one write port per register, loop gain resets to about 0.7
  genvar g;
  generate
    for (g = 0; g < `BAGC_NREG; g++)
    begin : g_reg
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          regs_ff[g] <= (g == 1) ? `BAGC_RST_LGAIN : `BAGC_RST_DEF;
        else if (ce_i && req_i.wr && hit && (idx == 4'(g)))
          regs_ff[g] <= req_i.wdata;
      end
    end
  endgenerate

  // table entries are loaded through data writes at the external table address;
  // no reset since software must fill the table before the loop is used
  always_ff @(posedge clk_i)
  begin
    if (ce_i && req_i.wr && hit && (idx == 4'h0))
      table_ff[table_addr_i] <= req_i.wdata[6:0];
  end

  // read mux, unmapped offsets answer zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (req_i.rd && hit)
    begin
      if (idx == 4'h0 && table_read_i)
        nxt_rdata = {1'b0, table_ff[table_addr_i]};
      else
        nxt_rdata = regs_ff[idx];
    end
  end

  // read data stands exactly one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rdata_ff <= 8'h00;
    else if (ce_i)
      rdata_ff <= nxt_rdata;
  end
  assign rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // field views

  bagc_byte_t tdata, lgain, mgain, atest, rfthr, satat, lwneg, csscl, txpwr, tm1, tm2;
  assign tdata = regs_ff[0];
  assign lgain = regs_ff[1];
  assign mgain = regs_ff[2];
  assign atest = regs_ff[3];
  assign rfthr = regs_ff[4];
  assign satat = regs_ff[5];
  assign lwneg = regs_ff[6];
  assign csscl = regs_ff[7];
  assign txpwr = regs_ff[8];
  assign tm1   = regs_ff[9];
  assign tm2   = regs_ff[10];

  ////////////////////////////////////////////////////////////////////////////////
  // gain path

  logic        rf_auto;
  logic        rf_sel;
  logic        ovr;
  logic [6:0]  nxt_if;
  logic        rf_ff;
  logic [6:0]  if_ff;
  logic signed [15:0] prod;

  assign ovr = atest[`BAGC_B_OVR];

  // threshold compare removes the pad; the disable bit hands rf back to the loop
  assign rf_auto = rfthr[7] ? agc_rf_i : (agc_voltage_i < rfthr[6:0]);
  // manual gain bit 7 replaces the loop decision while overriding
  assign rf_sel = ovr ? mgain[7] : rf_auto;
  assign nxt_if = ovr ? mgain[6:0] : agc_if_i;

  // gain lines are registered so override changes never glitch the pins
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rf_ff <= 1'b0;
      if_ff <= 7'h00;
    end
    else if (ce_i)
    begin
      rf_ff <= rf_sel ^ atest[`BAGC_B_RFPOL];
      if_ff <= nxt_if;
    end
  end
  assign rf_gain_line_o = rf_ff;
  assign if_gain_line_o = if_ff;

  // loop gain of 64 counts is unity, so nominal 0.7 is about 45
  assign prod = agc_err_i * $signed({1'b0, lgain[6:0]});
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      loop_update_o <= 8'sh00;
    else if (ce_i)
      loop_update_o <= prod[13:6];
  end

  // freeze stops updates unless continuous update is on
  assign agc_update_en_o = !agc_freeze_i || atest[`BAGC_B_CONT];

  // the dwell may end on lock, or early on weaker second antenna if allowed
  assign ant2_dwell_end_o = ant2_search_i
                            && (ant2_lock_i || (atest[`BAGC_B_ABORT] && ant2_power_low_i));

  ////////////////////////////////////////////////////////////////////////////////
  // final update after lock

  bagc_fin_e  fin_ff;
  bagc_fin_e  nxt_fin;
  logic [5:0] fcnt_ff;
  logic       lock_d_ff;
  logic       lock_rise;

  assign lock_rise = agc_lock_i && !lock_d_ff;

  // one window of samples once per lock; dropping lock re-arms it
  always_comb
  begin
    nxt_fin = fin_ff;
    case (fin_ff)
      BAGC_IDLE:
        if (lock_rise)
          nxt_fin = atest[`BAGC_B_XDIS] ? BAGC_DONE : BAGC_FINAL;
      BAGC_FINAL:
        if (!agc_lock_i)
          nxt_fin = BAGC_IDLE;
        else if (sample_stb_i && fcnt_ff == `BAGC_FINAL_SAMPLES - 6'h01)
          nxt_fin = BAGC_DONE;
      BAGC_DONE:
        if (!agc_lock_i)
          nxt_fin = BAGC_IDLE;
      default:
        nxt_fin = BAGC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      fin_ff    <= BAGC_IDLE;
      lock_d_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      fin_ff    <= nxt_fin;
      lock_d_ff <= agc_lock_i;
    end
  end

  // sample counter of the final window
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      fcnt_ff <= 6'h00;
    else if (ce_i)
    begin
      if (fin_ff != BAGC_FINAL)
        fcnt_ff <= 6'h00;
      else if (sample_stb_i)
        fcnt_ff <= fcnt_ff + 6'h01;
    end
  end
  assign final_update_o = (fin_ff == BAGC_FINAL);

  ////////////////////////////////////////////////////////////////////////////////
  // saturation attenuation

  logic [3:0] blk_lvl;
  logic       blocked;
  logic [4:0] nxt_step;

  // block level has an implied leading one, in half dB steps
  assign blk_lvl = {1'b1, lwneg[7:5]};
  assign blocked = !atest[`BAGC_B_SATEN] && (sat_level_i <= blk_lvl);

  // mid step outranks low step when both counts are exceeded
  always_comb
  begin
    nxt_step = 5'h00;
    if (blocked)
      nxt_step = 5'h00;
    else if (sat_count_i > {1'b0, saturation_count_register_i[7:4]})
      nxt_step = {satat[7:4], 1'b0};
    else if (sat_count_i > {1'b0, saturation_count_register_i[3:0]})
      nxt_step = {1'b0, satat[3:0]};
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      sat_atten_step_o <= 5'h00;
    else if (ce_i)
      sat_atten_step_o <= nxt_step;
  end

  // window magnitude is turned negative here, software writes it positive
  assign lock_window_neg_o = -$signed({1'b0, lwneg[4:0]});
  assign carrier_sense_second_scale_o = csscl[5:0];
  assign test_bus_select_o = regs_ff[11];

  ////////////////////////////////////////////////////////////////////////////////
  // transmit power

  logic       txe_d_ff;
  logic [6:0] txp_ff;

  // the converter sees a new value only at the start of a burst
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      txe_d_ff <= 1'b0;
      txp_ff   <= 7'h00;
    end
    else if (ce_i)
    begin
      txe_d_ff <= transmit_enable_input_i;
      if (transmit_enable_input_i && !txe_d_ff)
        txp_ff <= txpwr[7:1];
    end
  end
  assign tx_power_o = txp_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // test modes

  assign length_in_bits_o  = tm1[`BAGC_B_LENCNT];
  assign scrambler_off_o   = tm1[`BAGC_B_NOSCR];
  assign spread_off_o      = tm1[`BAGC_B_NOSPRD];
  assign force_high_rate_o = tm1[`BAGC_B_HIRATE];

  // pn generators need a zero write to arm before a one write starts them;
  // a one written without arming leaves them stopped
  logic [1:0] arm_ff;
  logic [1:0] pn_on_ff;
  logic [1:0] pn_init_ff;
  logic       tm1_wr;

  assign tm1_wr = ce_i && req_i.wr && hit && (idx == 4'h9);

  generate
    for (g = 0; g < 2; g++)
    begin : g_pn
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          arm_ff[g]     <= 1'b0;
          pn_on_ff[g]   <= 1'b0;
          pn_init_ff[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          pn_init_ff[g] <= 1'b0;
          if (tm1_wr)
          begin
            if (!req_i.wdata[g])
            begin
              arm_ff[g]   <= 1'b1;
              pn_on_ff[g] <= 1'b0;
            end
            else if (arm_ff[g])
            begin
              arm_ff[g]     <= 1'b0;
              pn_on_ff[g]   <= 1'b1;
              pn_init_ff[g] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  assign pn22_en_o   = pn_on_ff[`BAGC_B_PN22];
  assign pn44_en_o   = pn_on_ff[`BAGC_B_PN44];
  assign pn22_init_o = pn_init_ff[`BAGC_B_PN22];
  assign pn44_init_o = pn_init_ff[`BAGC_B_PN44];

  // adjust disable overrides both the forced and the automatic choice
  assign locked_tracking_o = !tm2[`BAGC_B_TADIS]
                             && (tm2[`BAGC_B_TTFORCE]
                                 || (service_bit2_i && receiver_config_bit2_i));

  // loopback ignores the outside world, so converter samples read zero
  assign loopback_o = tm2[`BAGC_B_LOOP];
  assign acq_lock_o = loopback_o && serial_data_input_i;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sample_i_o <= 6'h00;
      sample_q_o <= 6'h00;
    end
    else if (ce_i)
    begin
      if (loopback_o)
      begin
        sample_i_o <= 6'h00;
        sample_q_o <= 6'h00;
      end
      else if (tm2[`BAGC_B_BYPASS])
      begin
        sample_i_o <= {test_bus_inputs_i[3:0], 2'h0};
        sample_q_o <= {test_bus_inputs_i[7:4], 2'h0};
      end
      else
      begin
        sample_i_o <= adc_i_i;
        sample_q_o <= adc_q_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_table_read: assert property ((ce_i && req_i.rd && req_i.addr == `BAGC_OFS_TDATA
      && !table_read_i) |=> rdata_o == $past(tdata))
    else $error("table data readback wrong");
  chk_rf_override: assert property ((ce_i && ovr) |=> rf_gain_line_o
      == ($past(mgain[7]) ^ $past(atest[`BAGC_B_RFPOL])))
    else $error("rf line not following manual gain");
  chk_if_override: assert property ((ce_i && ovr) |=> if_gain_line_o == $past(mgain[6:0]))
    else $error("if line not following manual gain");
  chk_freeze_hold: assert property ((agc_freeze_i && !atest[`BAGC_B_CONT])
      |-> !agc_update_en_o)
    else $error("update allowed during freeze");
  chk_final_skip: assert property ((ce_i && lock_rise && atest[`BAGC_B_XDIS] && fin_ff == BAGC_IDLE)
      |=> !final_update_o)
    else $error("final update not skipped");
  chk_sat_block: assert property ((ce_i && blocked) |=> sat_atten_step_o == 5'h00)
    else $error("step applied while blocked");
  chk_tx_hold: assert property ((ce_i && !(transmit_enable_input_i && !txe_d_ff))
      |=> $stable(tx_power_o))
    else $error("tx power changed without enable edge");
  chk_lockwin_neg: assert property (lock_window_neg_o + $signed({1'b0, lwneg[4:0]}) == 6'sh00)
    else $error("lock window not negated");
  chk_tracking_off: assert property (tm2[`BAGC_B_TADIS] |-> !locked_tracking_o)
    else $error("tracking not disabled");
  chk_pn_arm: assert property ((ce_i && tm1_wr && req_i.wdata[0] && !arm_ff[0])
      |=> !pn22_init_o)
    else $error("pn started without zero write");

  cov_override: cover property (ce_i && ovr ##1 rf_gain_line_o);
  cov_final_win: cover property (final_update_o ##1 fin_ff == BAGC_DONE);
  cov_tx_load: cover property (transmit_enable_input_i && !txe_d_ff && ce_i);
  cov_pn_start: cover property (pn44_init_o);

endmodule

// *** tb/bagc_host_model.sv ***
// bus-master model of the controller that programs the agc/test bank
`timescale 1ns/10ps
module bagc_host_model
  import bagc_pkg::*;
(
  input  wire logic       clk_i,
  output bagc_req_s       req_o,
  input  wire logic [7:0] rdata_i
);
  initial req_o = '0;

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle write strobe, launched right after an edge, dropped after it is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req_o.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample inside it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_o.rd <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule

// *** tb/baseband_agc_test_config_tb.sv ***
// self-checking bench of the agc/test configuration bank
`timescale 1ns/10ps
module baseband_agc_test_config_tb
  import bagc_pkg::*;
;
  logic            clk_i, srst_i, ce_i, tbl_rd, cfg2, agc_rf, frz, lock, stb, a2s, a2p, a2l;
  logic            tx_en, svc2, serial_data_input;
  bagc_req_s       req;
  logic [7:0]      rdata, scr, tbus, d, v, t1, t2;
  logic [4:0]      taddr, satc;
  logic [6:0]      agc_if, volt;
  logic signed [7:0] err;
  logic [3:0]      satl;
  logic [5:0]      adc_i, adc_q, lwn, css, smp_i, smp_q;
  logic [6:0]      ifg, txp;
  logic [7:0]      tbsel;
  logic            rfg, fin, lbit, nscr, nspr, hir, pn44, pn22, pi44, pi22, trk, lpb, acq;
  logic            upen, dwell;
  logic signed [7:0] lupd;
  logic [4:0]      sstep;
  int              err_count, n_tests, cyc, pc;

  bagc_host_model host_u (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));

  bagc_regs dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .req_i(req), .rdata_o(rdata),
    .table_read_i(tbl_rd), .table_addr_i(taddr), .saturation_count_register_i(scr),
    .receiver_config_bit2_i(cfg2), .agc_rf_i(agc_rf), .agc_if_i(agc_if), .agc_voltage_i(volt),
    .agc_err_i(err), .agc_freeze_i(frz), .agc_lock_i(lock), .sample_stb_i(stb),
    .ant2_search_i(a2s), .ant2_power_low_i(a2p), .ant2_lock_i(a2l), .sat_count_i(satc),
    .sat_level_i(satl), .transmit_enable_input_i(tx_en), .service_bit2_i(svc2),
    .serial_data_input_i(serial_data_input), .test_bus_inputs_i(tbus), .adc_i_i(adc_i), .adc_q_i(adc_q),
    .rf_gain_line_o(rfg), .if_gain_line_o(ifg), .loop_update_o(lupd), .agc_update_en_o(upen),
    .final_update_o(fin), .ant2_dwell_end_o(dwell), .sat_atten_step_o(sstep),
    .lock_window_neg_o(lwn),
    .carrier_sense_second_scale_o(css), .tx_power_o(txp), .length_in_bits_o(lbit),
    .scrambler_off_o(nscr), .spread_off_o(nspr), .force_high_rate_o(hir), .pn44_en_o(pn44),
    .pn22_en_o(pn22), .pn44_init_o(pi44), .pn22_init_o(pi22), .locked_tracking_o(trk),
    .loopback_o(lpb), .acq_lock_o(acq), .sample_i_o(smp_i), .sample_q_o(smp_q),
    .test_bus_select_o(tbsel));

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // hang guard: the whole run needs well under 3000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished, errors so far %0d", s, err_count);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // locked tracking: forced or automatic, time adjust disable always wins
  function automatic logic trk_exp(input logic [7:0] m2, input logic s, input logic c);
    return !m2[3] && (m2[6] || (s && c));
  endfunction

  // samples: loopback zeroes them, bypass takes nibbles from the test bus
  function automatic logic [5:0] smp_exp(input logic [7:0] m2, input logic [3:0] n,
                                          input logic [5:0] a);
    return m2[2] ? 6'h00 : (m2[4] ? {n, 2'b00} : a);
  endfunction

  // loop update: gain of 64 counts is unity, so keep the product bits 13:6
  function automatic logic [7:0] lup_exp(input logic signed [7:0] e, input logic [6:0] g);
    logic signed [15:0] p;
    p = e * signed'(16'(g));
    return p[13:6];
  endfunction

  // attenuation step: attenuator holds {w[3:0], w[7:4]}, block level in w[7:5]
  function automatic logic [4:0] step_exp(input logic [7:0] a, input logic [7:0] w,
                                           input logic [3:0] l, input logic [4:0] c,
                                           input logic [7:0] s);
    if (!a[0] && (l <= {1'b1, w[7:5]}))
      return 5'h00;
    if (c > {1'b0, s[7:4]})
      return {w[3:0], 1'b0};
    if (c > {1'b0, s[3:0]})
      return {1'b0, w[7:4]};
    return 5'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {srst_i, ce_i} = 2'b11;
    {tbl_rd, cfg2, agc_rf, frz, lock, stb, a2s, a2p, a2l, tx_en, svc2, serial_data_input} = '0;
    {scr, tbus, taddr, satc, agc_if, volt, err, satl, adc_i, adc_q} = '0;
    void'($urandom(62));
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    // reset values, then two unmapped places
    for (int i = 0; i < 12; i++)
    begin
      host_u.rd(8'h2e + 8'(2 * i), d);
      chk(d, (i == 1) ? 8'h2d : 8'h00);
    end
    host_u.rd(8'h2f, d);
    chk(d, 8'h00);
    host_u.rd(8'h46, d);
    chk(d, 8'h00);
    // every register keeps all eight bits, back-to-back write then read
    for (int i = 0; i < 12; i++)
    begin
      v = 8'($urandom);
      host_u.wr(8'h2e + 8'(2 * i), v);
      host_u.rd(8'h2e + 8'(2 * i), d);
      chk(d, v);
      host_u.wr(8'h2e + 8'(2 * i), 8'h00);
    end
    done("regs");
    // table entries at two addresses, bit 7 never part of an entry
    taddr <= 5'h03;
    host_u.wr(8'h2e, 8'hff);
    taddr <= 5'h1c;
    host_u.wr(8'h2e, 8'h5a);
    tbl_rd <= 1'b1;
    taddr <= 5'h03;
    host_u.rd(8'h2e, d);
    chk(d, 8'h7f);
    taddr <= 5'h1c;
    host_u.rd(8'h2e, d);
    chk(d, 8'h5a);
    tbl_rd <= 1'b0;
    host_u.rd(8'h2e, d);
    chk(d, 8'h5a);
    done("table");
    // manual override with both polarities, loop path when override is off
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      agc_if <= 7'($urandom);
      host_u.wr(8'h34, {1'b0, i[0], 3'b000, i[1], 2'b00});
      host_u.wr(8'h32, v);
      settle(2);
      if (i[1])
      begin
        chk(8'(rfg), 8'(v[7] ^ i[0]));
        chk(8'(ifg), 8'(v[6:0]));
      end
      else
        chk(8'(ifg), 8'(agc_if));
    end
    // rf pad from threshold compare, or from the loop when threshold is off
    host_u.wr(8'h34, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      agc_rf <= 1'($urandom);
      volt <= i[0] ? 7'h10 : 7'h50;
      host_u.wr(8'h36, i[1] ? 8'hc0 : 8'h40);
      settle(2);
      chk(8'(rfg), 8'(i[1] ? agc_rf : !i[0] ? 1'b0 : 1'b1));
    end
    done("gain");
    // tx power moves only on a rising transmit enable
    for (int i = 0; i < 2; i++)
    begin
      d = {1'b0, txp};
      v = 8'($urandom);
      host_u.wr(8'h3e, v);
      settle(3);
      chk(8'(txp), d);
      tx_en <= 1'b1;
      settle(3);
      chk(8'(txp), 8'(v[7:1]));
      tx_en <= 1'b0;
    end
    done("txpower");
    // field outputs, tracking, loopback and bypass over random settings
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($urandom);
      t1 = 8'($urandom) & 8'hfc;
      t2 = 8'($urandom);
      {svc2, cfg2, serial_data_input, frz, a2s, a2p, a2l} <= 7'($urandom);
      d = 8'($urandom);
      {tbus, adc_i, adc_q, satc, satl, scr, err} <= 45'({$urandom, $urandom});
      host_u.wr(8'h3a, v);
      host_u.wr(8'h3c, v);
      host_u.wr(8'h40, t1);
      host_u.wr(8'h42, t2);
      host_u.wr(8'h44, v);
      host_u.wr(8'h30, v);
      host_u.wr(8'h34, d);
      host_u.wr(8'h38, {v[3:0], v[7:4]});
      settle(2);
      chk(8'(lwn), 8'(6'(6'h00 - {1'b0, v[4:0]})));
      chk(8'(lupd), 8'(lup_exp(err, v[6:0])));
      chk(8'({upen, dwell}), 8'({!frz || d[7], a2s && (a2l || (d[1] && a2p))}));
      chk(8'(sstep), 8'(step_exp(d, v, satl, satc, scr)));
      chk(8'(css), 8'(v[5:0]));
      chk(8'(tbsel), v);
      chk(8'({lbit, hir, nspr, nscr}), 8'({t1[5], t1[6], t1[3], t1[2]}));
      chk(8'(trk), 8'(trk_exp(t2, svc2, cfg2)));
      chk(8'({lpb, acq}), 8'({t2[2], t2[2] & serial_data_input}));
      chk(8'(smp_i), 8'(smp_exp(t2, tbus[3:0], adc_i)));
      chk(8'(smp_q), 8'(smp_exp(t2, tbus[7:4], adc_q)));
    end
    // a write while the clock enable is low must leave the register alone
    ce_i <= 1'b0;
    host_u.wr(8'h3c, ~v);
    ce_i <= 1'b1;
    host_u.rd(8'h3c, d);
    chk(d, v);
    done("fields");
    // second reset in mid-run, then pn enables without and with arming
    srst_i <= 1'b1;
    settle(2);
    srst_i <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      pc = 0;
      if (i == 1)
        host_u.wr(8'h40, 8'h00);
      host_u.wr(8'h40, 8'h03);
      // the init pulse stands only in the cycle right after the write is taken
      repeat (4)
      begin
        #1;
        pc += int'(pi44 === 1'b1) + int'(pi22 === 1'b1);
        @(posedge clk_i);
      end
      chk(8'(pc), 8'(2 * i));
      chk(8'({pn44, pn22}), 8'(i ? 2'b11 : 2'b00));
    end
    done("pn");
    // final update lasts exactly 32 samples after lock, none when disabled
    host_u.wr(8'h34, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      lock <= 1'b1;
      settle(2);
      chk(8'(fin), 8'(i == 0));
      repeat (31)
      begin
        @(posedge clk_i);
        stb <= 1'b1;
        @(posedge clk_i);
        stb <= 1'b0;
      end
      settle(2);
      chk(8'(fin), 8'(i == 0));
      stb <= 1'b1;
      settle(1);
      stb <= 1'b0;
      settle(2);
      chk(8'(fin), 8'h00);
      lock <= 1'b0;
      host_u.wr(8'h34, 8'h20);
    end
    done("final");
    complete_run();
  end
endmodule
